/* File: pvsc_pkg.sv */
// package: register map, field layout and timing for the pin volume converter control
package pvsc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] PAGE_SEL_IDX  = 8'h00;
	localparam logic [7:0] CTRL_IDX      = 8'h74;
	localparam logic [7:0] GAIN_IDX      = 8'h75;
	localparam logic [7:0] VOL_PAGE      = 8'h00;
	localparam int         IDX_LSB       = 2;

	// reset values
	localparam logic [7:0] PAGE_RESET    = 8'h00;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [6:0] GAIN_RESET    = 7'h00;
	localparam logic       GAIN_TOP_RST  = 1'b0;

	// gain code landmarks
	localparam logic [6:0] GAIN_ZERO_DB  = 7'h24;
	localparam logic [6:0] GAIN_HALF_END = 7'h5a;
	localparam logic [6:0] GAIN_MIN      = 7'h7e;
	localparam logic [6:0] GAIN_RSVD     = 7'h7f;

	// sar start: top trial bit
	localparam logic [2:0] SAR_TOP_BIT   = 3'h6;
	localparam logic [6:0] SAR_FIRST     = 7'h40;

	// timing: slowest throughput at the nominal master clock
	localparam longint MCLK_NOM_HZ       = 64'd12000000;
	localparam longint SLOW_RATE_MHZ     = 64'd15625;
	localparam longint CONV_DIV_NOM      = (MCLK_NOM_HZ * 64'd1000) / SLOW_RATE_MHZ;
	localparam int     RATE_CODES        = 8;

	// control register layout, bit 7 first
	typedef struct packed {
		logic       pin_mode;
		logic       osc_clk;
		logic [1:0] hyst;
		logic       rsvd;
		logic [2:0] rate;
	} pvsc_ctrl_t;

	typedef enum logic [1:0] {
		PVSC_HYST_NONE = 2'h0,
		PVSC_HYST_ONE  = 2'h1,
		PVSC_HYST_TWO  = 2'h2,
		PVSC_HYST_RSVD = 2'h3
	} pvsc_hyst_t;

	// gray along idle -> convert -> update
	typedef enum logic [1:0] {
		PVSC_IDLE   = 2'h0,
		PVSC_CONV   = 2'h1,
		PVSC_UPDATE = 2'h3
	} pvsc_state_t;

endpackage

/* File: pvsc_top.sv */
// pin volume sar converter control: ahb-lite registers, conversion timing and gain readback
`timescale 1ns/1ps
// Summary of operation
// - bit 7 of the control register picks register volume with the converter off (0) or pin volume (1).
// - bit 6 of the control register clocks the converter from the master clock or the internal oscillator.
// - bits 5:4 give no hysteresis, one code or two codes, and software never writes 11.
// - bits 2:0 set throughput, 15.625 Hz at code 000 on a 12 MHz master clock, doubling per code to 2 kHz.
// - on the oscillator the same divisors apply, so rates scale with the oscillator frequency.
// - readback code 0 is 18 dB, falling 0.5 dB per step to 0 dB at 0x24 and -27 dB at 0x5a.
// - from 0x5b at -28 dB the readback falls 1 dB per step to -63 dB at 0x7e, and 0x7f is never a gain.
// - index 0 on every page is the page selector, and page 0 holds the volume registers.
module pvsc_top #(
	parameter int     ADDR_W        = 32,
	parameter int     DIV_W         = 20,
	parameter longint CONV_DIV_BASE = pvsc_pkg::CONV_DIV_NOM
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              mclk_tick,
	input  wire logic              osc_tick,
	input  wire logic              sar_above,
	input  wire logic [6:0]        reg_volume,
	output logic                   sar_power_en,
	output logic                   sar_clk_osc,
	output logic      [6:0]        sar_trial,
	output logic                   vol_from_pin,
	output logic      [6:0]        playback_volume
);

	// refused at elaboration: the map needs ten address bits
	if (ADDR_W < 10 || ADDR_W > 32)
	begin
		$error("pvsc_top: ADDR_W must be 10 to 32");
	end
	if (DIV_W < 8 || DIV_W > 32)
	begin
		$error("pvsc_top: DIV_W must be 8 to 32");
	end
	if (CONV_DIV_BASE < 128 || CONV_DIV_BASE >= (64'd1 << DIV_W))
	begin
		$error("pvsc_top: CONV_DIV_BASE must be at least 128 and fit DIV_W bits");
	end

	localparam logic [DIV_W-1:0] DIV_BASE = DIV_W'(CONV_DIV_BASE);

	logic [7:0]              page;
	pvsc_pkg::pvsc_ctrl_t    ctrl;
	logic [6:0]              gain;
	logic                    gain_top;
	logic                    gain_seen;
	logic                    wr_pend;
	logic [7:0]              wr_idx;
	logic [7:0]              next_page;
	pvsc_pkg::pvsc_ctrl_t    next_ctrl;
	logic                    next_gain_top;
	logic                    addr_ok;
	logic                    acc;
	logic [7:0]              acc_idx;
	logic [DIV_W-1:0]        div_cnt;
	logic [DIV_W-1:0]        period;
	logic                    src_tick;
	logic                    conv_start;
	pvsc_pkg::pvsc_state_t   state;
	logic [2:0]              bit_idx;
	logic [6:0]              result;
	logic [6:0]              trial_kept;
	logic [6:0]              reading;
	logic [6:0]              diff;
	logic [6:0]              hyst_amt;
	logic [7:0]              rd_byte;

	// address phase decode: word aligned, nothing above the map
	assign acc     = hsel && hready && htrans[1];
	assign acc_idx = haddr[pvsc_pkg::IDX_LSB+7:pvsc_pkg::IDX_LSB];
	assign addr_ok = (haddr[1:0] == 2'h0) && (haddr[ADDR_W-1:10] == '0);

	// writes land in the data phase; next_ values also feed the read mux so a
	// read right behind a write sees the new value
	always_comb
	begin
		next_page     = page;
		next_ctrl     = ctrl;
		next_gain_top = gain_top;
		if (wr_pend)
		begin
			if (wr_idx == pvsc_pkg::PAGE_SEL_IDX)
				next_page = hwdata[7:0];
			else if (page == pvsc_pkg::VOL_PAGE && wr_idx == pvsc_pkg::CTRL_IDX)
				next_ctrl = pvsc_pkg::pvsc_ctrl_t'(hwdata[7:0]);
			else if (page == pvsc_pkg::VOL_PAGE && wr_idx == pvsc_pkg::GAIN_IDX)
				next_gain_top = hwdata[7];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_idx  <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend <= acc && hwrite && addr_ok;
			wr_idx  <= acc_idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			page     <= pvsc_pkg::PAGE_RESET;
			ctrl     <= pvsc_pkg::pvsc_ctrl_t'(pvsc_pkg::CTRL_RESET);
			gain_top <= pvsc_pkg::GAIN_TOP_RST;
		end
		else
		begin
			page     <= next_page;
			ctrl     <= next_ctrl;
			gain_top <= next_gain_top;
		end
	end

	// read mux on the address phase, looking through a write still in flight
	always_comb
	begin
		rd_byte = 8'h00;
		if (acc_idx == pvsc_pkg::PAGE_SEL_IDX)
			rd_byte = next_page;
		else if (next_page == pvsc_pkg::VOL_PAGE && acc_idx == pvsc_pkg::CTRL_IDX)
			rd_byte = next_ctrl;
		else if (next_page == pvsc_pkg::VOL_PAGE && acc_idx == pvsc_pkg::GAIN_IDX)
			rd_byte = {next_gain_top, gain};
	end

	// zero wait state slave, always okay; read data caught in the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			if (acc && !hwrite && addr_ok)
				hrdata <= {24'h00_0000, rd_byte};
		end
	end

	// throughput divider counts source ticks; one divisor table serves both
	// sources, so oscillator rates follow its actual frequency
	assign src_tick   = ctrl.osc_clk ? osc_tick : mclk_tick;
	assign period     = DIV_BASE >> ctrl.rate;
	assign conv_start = src_tick && (div_cnt >= period - DIV_W'(1));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_cnt <= '0;
		else if (!ctrl.pin_mode)
			div_cnt <= '0;
		else if (conv_start)
			div_cnt <= '0;
		else if (src_tick)
			div_cnt <= div_cnt + DIV_W'(1);
	end

	// one sar decision per source tick; the comparator says pin above trial
	assign trial_kept = sar_above ? sar_trial : (sar_trial & ~(7'h01 << bit_idx));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state     <= pvsc_pkg::PVSC_IDLE;
			bit_idx   <= 3'h0;
			sar_trial <= 7'h00;
			result    <= 7'h00;
		end
		else if (!ctrl.pin_mode)
		begin
			state     <= pvsc_pkg::PVSC_IDLE;
			bit_idx   <= 3'h0;
			sar_trial <= 7'h00;
		end
		else
		begin
			unique case (state)
				pvsc_pkg::PVSC_IDLE:
				begin
					if (conv_start)
					begin
						state     <= pvsc_pkg::PVSC_CONV;
						bit_idx   <= pvsc_pkg::SAR_TOP_BIT;
						sar_trial <= pvsc_pkg::SAR_FIRST;
					end
				end
				pvsc_pkg::PVSC_CONV:
				begin
					if (src_tick)
					begin
						if (bit_idx == 3'h0)
						begin
							result <= trial_kept;
							state  <= pvsc_pkg::PVSC_UPDATE;
						end
						else
						begin
							sar_trial <= trial_kept | (7'h01 << (bit_idx - 3'h1));
							bit_idx   <= bit_idx - 3'h1;
						end
					end
				end
				pvsc_pkg::PVSC_UPDATE:
					state <= pvsc_pkg::PVSC_IDLE;
				// the one unused code falls back to idle
				default:
					state <= pvsc_pkg::PVSC_IDLE;
			endcase
		end
	end

	// the all-ones reading is not a gain, so it lands on the lowest step
	assign reading = (result == pvsc_pkg::GAIN_RSVD) ? pvsc_pkg::GAIN_MIN : result;
	assign diff    = (reading > gain) ? (reading - gain) : (gain - reading);

	// the forbidden hysteresis code is treated as two codes
	always_comb
	begin
		unique case (pvsc_pkg::pvsc_hyst_t'(ctrl.hyst))
			pvsc_pkg::PVSC_HYST_NONE: hyst_amt = 7'h00;
			pvsc_pkg::PVSC_HYST_ONE:  hyst_amt = 7'h01;
			pvsc_pkg::PVSC_HYST_TWO:  hyst_amt = 7'h02;
			pvsc_pkg::PVSC_HYST_RSVD: hyst_amt = 7'h02;
		endcase
	end

	// first reading after entering pin mode is taken whole, later ones
	// only when they move past the hysteresis band
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gain      <= pvsc_pkg::GAIN_RESET;
			gain_seen <= 1'b0;
		end
		else if (!ctrl.pin_mode)
			gain_seen <= 1'b0;
		else if (state == pvsc_pkg::PVSC_UPDATE && (!gain_seen || diff > hyst_amt))
		begin
			gain      <= reading;
			gain_seen <= 1'b1;
		end
	end

	// analog controls; the clock pick tracks the register with no lag, so the
	// converter never runs a cycle on the source just left
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sar_power_en <= 1'b0;
			sar_clk_osc  <= 1'b0;
		end
		else
		begin
			sar_power_en <= ctrl.pin_mode;
			sar_clk_osc  <= next_ctrl.osc_clk;
		end
	end

	// playback gain, from a flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vol_from_pin    <= 1'b0;
			playback_volume <= pvsc_pkg::GAIN_ZERO_DB;
		end
		else
		begin
			vol_from_pin    <= ctrl.pin_mode && gain_seen;
			playback_volume <= (ctrl.pin_mode && gain_seen) ? gain : reg_volume;
		end
	end

endmodule

/* File: pvsc_sva.sv */
// checker: port assertions for the pin volume sar control
`timescale 1ns/1ps
module pvsc_sva (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        mclk_tick,
	input wire logic        osc_tick,
	input wire logic [6:0]  reg_volume,
	input wire logic        sar_power_en,
	input wire logic        sar_clk_osc,
	input wire logic [6:0]  sar_trial,
	input wire logic        vol_from_pin,
	input wire logic [6:0]  playback_volume
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// converter off for two samples in a row
	sequence s_off;
		!sar_power_en ##1 !sar_power_en;
	endsequence
	a_bus_ready: assert property (hreadyout) else $error("bus stalled");
	a_resp_okay: assert property (!hresp) else $error("bad response");
	a_rd_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits");
	a_trial_off: assert property (s_off |-> sar_trial == 7'h00) else $error("trial while off");
	a_trial_tick: assert property (sar_trial != 7'h00 && $changed(sar_trial) |->
		$past(sar_clk_osc ? osc_tick : mclk_tick)) else $error("trial off tick");
	a_no_rsvd: assert property (vol_from_pin |-> playback_volume != 7'h7f)
		else $error("reserved gain");
	a_reg_path: assert property ($past(hresetn) && !vol_from_pin && $past(!vol_from_pin)
		|-> playback_volume == $past(reg_volume)) else $error("register volume lost");
	a_pin_power: assert property ($rose(vol_from_pin) |-> $past(sar_power_en, 2))
		else $error("pin gain unpowered");
endmodule
bind pvsc_top pvsc_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .mclk_tick(mclk_tick), .osc_tick(osc_tick),
	.reg_volume(reg_volume), .sar_power_en(sar_power_en), .sar_clk_osc(sar_clk_osc),
	.sar_trial(sar_trial), .vol_from_pin(vol_from_pin), .playback_volume(playback_volume));

/* File: pvsc_pin_model.sv */
// partner: comparator on the volume detect pin
`timescale 1ns/1ps
module pvsc_pin_model (
	input  wire logic [6:0] pin_level,
	input  wire logic [6:0] sar_trial,
	input  wire logic       sar_power_en,
	output logic            sar_above
);
	// unpowered comparator wanders, never a clean level
	logic wander = 1'b0;
	always #37 wander = ~wander;
	assign sar_above = sar_power_en ? pin_level >= sar_trial : wander;
endmodule

/* File: tb_pin_volume_sar_control.sv */
// testbench: registers and pin volume conversion
`timescale 1ns/1ps
module tb_pin_volume_sar_control;
	localparam int DIV_BASE_TB = 128;
	localparam int MCLK_GAP    = 4;
	localparam int OSC_GAP     = 5;
	logic        hclk = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic        clk_osc;
	logic        from_pin;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	wire         hready;
	logic        mclk_tick = 1'b0;
	logic        osc_tick = 1'b0;
	logic        mclk_run = 1'b1;
	logic        above;
	logic [6:0]  reg_volume = 7'h11;
	logic [6:0]  pin_level = 7'h30;
	logic        power_en;
	logic [6:0]  trial;
	logic [6:0]  vol;
	int          err_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	initial forever #25 hclk = ~hclk;
	// sources at different rates, so a wrong source pick shows
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		mclk_tick <= mclk_run && cyc % MCLK_GAP == 0;
		osc_tick <= cyc % OSC_GAP == 0;
	end
	pvsc_top #(.CONV_DIV_BASE(DIV_BASE_TB)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
		.mclk_tick(mclk_tick), .osc_tick(osc_tick), .sar_above(above),
		.reg_volume(reg_volume), .sar_clk_osc(clk_osc), .sar_power_en(power_en),
		.sar_trial(trial), .vol_from_pin(from_pin), .playback_volume(vol));
	pvsc_pin_model PIN (.pin_level(pin_level), .sar_trial(trial), .sar_power_en(power_en),
		.sar_above(above));
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				err_count++;
				end_of_test();
			end
			@(posedge hclk);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		hsize <= 3'h2;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		rdy();
		if (!wr)
			chk(hrdata, d);
	endtask
	task automatic wait_vol(input logic [6:0] e);
		int n;
		n = 0;
		while (vol !== e && n < 600)
		begin
			n++;
			@(posedge hclk);
		end
		chk({25'h0, vol}, {25'h0, e});
		if (vol !== e)
			end_of_test();
	endtask
	// waits for the next rise of a conversion start (trial at its first code)
	task automatic wait_start(output int n);
		logic was;
		n = 0;
		was = 1'b1;
		while (n < 3000 && !(trial === 7'h40 && !was))
		begin
			was = (trial === 7'h40);
			@(posedge hclk);
			n++;
		end
		if (n == 3000)
		begin
			err_count++;
			end_of_test();
		end
	endtask
	// start to start spacing; leaving pin mode first clears the divider
	task automatic t_rate(input logic [2:0] code, input logic osc, input int exp_cyc);
		int n;
		bus(32'h1d0, 1'b1, 32'h00);
		bus(32'h1d0, 1'b1, {24'h0, 1'b1, osc, 3'h0, code});
		wait_start(n);
		wait_start(n);
		chk(n, exp_cyc);
	endtask
	task automatic t_regs();
		bus(32'h000, 1'b0, 32'h00);
		bus(32'h1d0, 1'b0, 32'h00);
		bus(32'h1d4, 1'b0, 32'h00);
		bus(32'h1d0, 1'b1, 32'h25);
		bus(32'h1d0, 1'b0, 32'h25);
		bus(32'h1d4, 1'b1, 32'h00);
		bus(32'h1d4, 1'b0, 32'h00);
		bus(32'h1f0, 1'b0, 32'h00);
		bus(32'h000, 1'b1, 32'h01);
		bus(32'h1d0, 1'b0, 32'h00);
		bus(32'h000, 1'b1, 32'h00);
		bus(32'h1d0, 1'b0, 32'h25);
		bus(32'h1d4, 1'b1, 32'h00);
		chk({25'h0, vol}, 32'h11);
	endtask
	task automatic t_pin();
		bus(32'h1d0, 1'b1, 32'h87);
		wait_vol(7'h30);
		bus(32'h1d4, 1'b0, 32'h30);
		bus(32'h1d0, 1'b1, 32'ha7);
		pin_level <= 7'h32;
		repeat (200) @(posedge hclk);
		chk({25'h0, vol}, 32'h30);
		pin_level <= 7'h33;
		wait_vol(7'h33);
		bus(32'h1d0, 1'b1, 32'h97);
		pin_level <= 7'h35;
		wait_vol(7'h35);
		pin_level <= 7'h7f;
		wait_vol(7'h7e);
		bus(32'h1d4, 1'b0, 32'h7e);
		bus(32'h1d0, 1'b1, 32'h00);
	endtask
	task automatic t_osc();
		mclk_run <= 1'b0;
		pin_level <= 7'h24;
		bus(32'h1d0, 1'b1, 32'hc6);
		wait_vol(7'h24);
		chk({31'h0, clk_osc}, 32'h1);
		chk({31'h0, from_pin}, 32'h1);
		mclk_run <= 1'b1;
		reg_volume <= 7'h5b;
		bus(32'h1d0, 1'b1, 32'h00);
		wait_vol(7'h5b);
		chk({31'h0, from_pin}, 32'h0);
	endtask
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_pin();
		t_osc();
		t_rate(3'h0, 1'b0, DIV_BASE_TB * MCLK_GAP);
		t_rate(3'h3, 1'b0, (DIV_BASE_TB >> 3) * MCLK_GAP);
		t_rate(3'h0, 1'b1, DIV_BASE_TB * OSC_GAP);
		end_of_test();
	end
endmodule
